/* File: logic/vout_limit_freq_config_regs.sv */
// Output-voltage ceiling, margin, slew, duty cap, switching frequency and
// efficiency-mode configuration bank of a single-output PWM controller.
// Assumes a command decoder on the same clock delivers whole-word accesses,
// and that strap levels arrive straight from pins.
module vout_limit_freq_config_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command access
  input wire pmbus_cfg_pkg::reg_req_t req,
  output logic [15:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic wr_reject_ff,
  // Strap pins
  input wire pmbus_cfg_pkg::strap_t strap_pin,
  // Operating context
  input wire pmbus_cfg_pkg::margin_sel_t margin_sel,
  input wire logic power_transition,
  // Derived controls
  output logic defaults_loaded_ff,
  output logic [15:0] vout_target_ff,
  output logic vout_settled_ff,
  output logic [9:0] duty_cap_ff,
  output logic [7:0] switch_divisor_ff,
  output logic divisor_valid_ff,
  output logic diode_emulation_ff
);
  import pmbus_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Strap voltage times a 1.16 fixed-point factor, saturated to a word
  function automatic logic [15:0] scale_strap(input logic [15:0] vset,
                                              input logic [16:0] factor);
    logic [32:0] prod;
    logic [16:0] shifted;
    prod = {17'h00000, vset} * {16'h0000, factor};
    shifted = prod[SCALE_SHIFT +: 17];
    if (shifted[16]) begin
      scale_strap = 16'hFFFF;
    end else begin
      scale_strap = shifted[15:0];
    end
  endfunction : scale_strap

  // Margin set points share one acceptance window
  function automatic logic margin_ok(input logic [15:0] value, input logic [15:0] ceil);
    margin_ok = (value >= VOUT_MIN_CODE) && (value <= ceil);
  endfunction : margin_ok

  // ----------------------------------------------------------------------
  // Strap synchronisers and default load
  // ----------------------------------------------------------------------
  strap_t strap_meta_ff;
  strap_t strap_sync_ff;
  logic [1:0] settle_ff;
  logic [1:0] nxt_settle;
  logic nxt_loaded;
  logic load_now;

  // Straps are pin levels, so two flops before anything reads them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta_ff <= '0;
      strap_sync_ff <= '0;
    end else begin
      strap_meta_ff <= strap_pin;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // Wait until the synchroniser holds real strap levels, then load once
  always_comb begin
    nxt_settle = settle_ff;
    if (settle_ff != STRAP_SETTLE) begin
      nxt_settle = settle_ff + 2'h1;
    end
    load_now = !defaults_loaded_ff && (settle_ff == STRAP_SETTLE);
    nxt_loaded = defaults_loaded_ff || load_now;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_ff <= '0;
      defaults_loaded_ff <= 1'b0;
    end else begin
      settle_ff <= nxt_settle;
      defaults_loaded_ff <= nxt_loaded;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [15:0] command_ff;
  logic [15:0] ceiling_ff;
  logic [15:0] margin_high_ff;
  logic [15:0] margin_low_ff;
  logic [15:0] slew_ff;
  logic [15:0] duty_word_ff;
  logic [15:0] freq_word_ff;
  logic [7:0] eff_mode_ff;
  logic [15:0] nxt_command;
  logic [15:0] nxt_ceiling;
  logic [15:0] nxt_margin_high;
  logic [15:0] nxt_margin_low;
  logic [15:0] nxt_slew;
  logic [15:0] nxt_duty_word;
  logic [15:0] nxt_freq_word;
  logic [7:0] nxt_eff_mode;
  logic nxt_reject;
  logic scan_start;
  logic signed [31:0] wr_duty;
  logic signed [31:0] wr_freq;

  // Write acceptance; a refused write only raises the reject pulse
  always_comb begin
    nxt_command = command_ff;
    nxt_ceiling = ceiling_ff;
    nxt_margin_high = margin_high_ff;
    nxt_margin_low = margin_low_ff;
    nxt_slew = slew_ff;
    nxt_duty_word = duty_word_ff;
    nxt_freq_word = freq_word_ff;
    nxt_eff_mode = eff_mode_ff;
    nxt_reject = 1'b0;
    scan_start = 1'b0;
    wr_duty = linear11_value(req.data, DUTY_FRAC_BITS);
    wr_freq = linear11_value(req.data, 0);
    if (load_now) begin
      nxt_command = strap_sync_ff.vset;
      nxt_ceiling = scale_strap(strap_sync_ff.vset, CEIL_SCALE);
      nxt_margin_high = scale_strap(strap_sync_ff.vset, MARGIN_HIGH_SCALE);
      nxt_margin_low = scale_strap(strap_sync_ff.vset, MARGIN_LOW_SCALE);
      nxt_freq_word = strap_sync_ff.freq;
      nxt_eff_mode = {7'h00, strap_sync_ff.diode_emulation};
      scan_start = 1'b1;
    end else if (defaults_loaded_ff && req.wr) begin
      if (req.code == CMD_VOUT_COMMAND) begin
        if (req.data > ceiling_ff) begin
          nxt_reject = 1'b1;
        end else begin
          nxt_command = req.data;
        end
      end else if (req.code == CMD_CEILING) begin
        if (req.data < VOUT_MIN_CODE || req.data > OUTPUT_VOLTAGE_CEILING_CODE) begin
          nxt_reject = 1'b1;
        end else begin
          nxt_ceiling = req.data;
        end
      end else if (req.code == CMD_MARGIN_HIGH) begin
        if (margin_ok(req.data, ceiling_ff)) begin
          nxt_margin_high = req.data;
        end else begin
          nxt_reject = 1'b1;
        end
      end else if (req.code == CMD_MARGIN_LOW) begin
        if (margin_ok(req.data, ceiling_ff)) begin
          nxt_margin_low = req.data;
        end else begin
          nxt_reject = 1'b1;
        end
      end else if (req.code == CMD_SLEW_RATE) begin
        nxt_slew = req.data;
      end else if (req.code == CMD_DUTY_CAP) begin
        if (wr_duty < 0 || wr_duty > signed'({22'h000000, DUTY_CAP_MAX})) begin
          nxt_reject = 1'b1;
        end else begin
          nxt_duty_word = req.data;
        end
      end else if (req.code == CMD_SWITCH_FREQ) begin
        if (wr_freq < FREQ_MIN_KHZ || wr_freq > FREQ_MAX_KHZ) begin
          nxt_reject = 1'b1;
        end else begin
          nxt_freq_word = req.data;
          scan_start = 1'b1;
        end
      end else if (req.code == CMD_EFF_MODE) begin
        nxt_eff_mode = {7'h00, req.data[EFF_DEM_BIT]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      command_ff <= '0;
      ceiling_ff <= '0;
      margin_high_ff <= '0;
      margin_low_ff <= '0;
      slew_ff <= SLEW_RESET;
      duty_word_ff <= DUTY_CAP_RESET;
      freq_word_ff <= '0;
      eff_mode_ff <= '0;
      wr_reject_ff <= 1'b0;
    end else begin
      command_ff <= nxt_command;
      ceiling_ff <= nxt_ceiling;
      margin_high_ff <= nxt_margin_high;
      margin_low_ff <= nxt_margin_low;
      slew_ff <= nxt_slew;
      duty_word_ff <= nxt_duty_word;
      freq_word_ff <= nxt_freq_word;
      eff_mode_ff <= nxt_eff_mode;
      wr_reject_ff <= nxt_reject;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [15:0] nxt_rd_data;
  logic nxt_rd_valid;

  // Unmapped codes answer zero so the framer never waits
  always_comb begin
    nxt_rd_valid = req.rd;
    nxt_rd_data = '0;
    if (req.code == CMD_VOUT_COMMAND) begin
      nxt_rd_data = command_ff;
    end else if (req.code == CMD_CEILING) begin
      nxt_rd_data = ceiling_ff;
    end else if (req.code == CMD_MARGIN_HIGH) begin
      nxt_rd_data = margin_high_ff;
    end else if (req.code == CMD_MARGIN_LOW) begin
      nxt_rd_data = margin_low_ff;
    end else if (req.code == CMD_SLEW_RATE) begin
      nxt_rd_data = slew_ff;
    end else if (req.code == CMD_DUTY_CAP) begin
      nxt_rd_data = duty_word_ff;
    end else if (req.code == CMD_SWITCH_FREQ) begin
      nxt_rd_data = freq_word_ff;
    end else if (req.code == CMD_EFF_MODE) begin
      nxt_rd_data = {8'h00, eff_mode_ff};
    end
    if (!req.rd) begin
      nxt_rd_data = rd_data_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= '0;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  // ----------------------------------------------------------------------
  // Output target selection and slew
  // ----------------------------------------------------------------------
  logic [15:0] goal_pick;
  logic [15:0] goal;
  logic signed [31:0] rate_raw;
  logic [31:0] rate_lsb;
  logic ramp_instant;

  // Margin selection first, then the ceiling clips whatever was chosen
  always_comb begin
    case (margin_sel)
      MARGIN_HIGH: goal_pick = margin_high_ff;
      MARGIN_LOW: goal_pick = margin_low_ff;
      default: goal_pick = command_ff;
    endcase
    goal = (goal_pick > ceiling_ff) ? ceiling_ff : goal_pick;
    rate_raw = linear11_value(slew_ff, VOUT_EXP_SHIFT);
    // A rate below one LSB per ms would never arrive, so it is floored
    rate_lsb = (rate_raw < 1) ? 32'h00000001 : rate_raw;
    ramp_instant = power_transition || !defaults_loaded_ff || (slew_ff == SLEW_FASTEST);
  end

  target_ramp u_ramp (
    .clk(clk),
    .rst_n(rst_n),
    .goal(goal),
    .rate_per_ms(rate_lsb),
    .instant(ramp_instant),
    .target_ff(vout_target_ff),
    .settled_ff(vout_settled_ff)
  );

  // ----------------------------------------------------------------------
  // Duty cap and diode emulation
  // ----------------------------------------------------------------------
  logic signed [31:0] duty_val;
  logic [9:0] nxt_duty_cap;

  // Stored word is already range-checked; clamp again as a safety net
  always_comb begin
    duty_val = linear11_value(duty_word_ff, DUTY_FRAC_BITS);
    if (duty_val < 0) begin
      nxt_duty_cap = '0;
    end else if (duty_val > signed'({22'h000000, DUTY_CAP_MAX})) begin
      nxt_duty_cap = DUTY_CAP_MAX;
    end else begin
      nxt_duty_cap = duty_val[9:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_cap_ff <= DUTY_CAP_MAX;
      diode_emulation_ff <= 1'b0;
    end else begin
      duty_cap_ff <= nxt_duty_cap;
      diode_emulation_ff <= eff_mode_ff[EFF_DEM_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Switching divisor search
  // ----------------------------------------------------------------------
  scan_state_t scan_ff;
  scan_state_t nxt_scan;
  logic [7:0] n_ff;
  logic [7:0] nxt_n;
  logic [7:0] nxt_divisor;
  logic nxt_div_valid;
  logic signed [31:0] f_raw;
  logic [16:0] f_khz;
  logic [33:0] near_lhs;
  logic [33:0] near_rhs;

  // Walk n upward; the first n whose midpoint to n+1 lies below f is nearest.
  // One n per cycle trades 121 cycles of latency for no divider.
  always_comb begin
    f_raw = linear11_value(freq_word_ff, 0);
    if (f_raw < 0) begin
      f_khz = '0;
    end else if (f_raw > 32'sh0001FFFF) begin
      f_khz = 17'h1FFFF;
    end else begin
      f_khz = f_raw[16:0];
    end
    // Midpoint taken in frequency, not in period: f*2n(n+1) >= base*(2n+1)
    near_lhs = (34'(f_khz) * 34'(n_ff) * 34'({1'b0, n_ff} + 9'h001)) << 1;
    near_rhs = 34'(FSW_BASE_KHZ) * 34'({n_ff, 1'b1});
    nxt_scan = scan_ff;
    nxt_n = n_ff;
    nxt_divisor = switch_divisor_ff;
    nxt_div_valid = divisor_valid_ff;
    case (scan_ff)
      SCAN_IDLE: begin
        if (scan_start) begin
          nxt_scan = SCAN_RUN;
          nxt_n = DIV_MIN;
          nxt_div_valid = 1'b0;
        end
      end
      SCAN_RUN: begin
        if (scan_start) begin
          nxt_n = DIV_MIN;
        end else if (near_lhs >= near_rhs || n_ff == DIV_MAX) begin
          nxt_divisor = n_ff;
          nxt_div_valid = 1'b1;
          nxt_scan = SCAN_IDLE;
        end else begin
          nxt_n = n_ff + 8'h01;
        end
      end
      default: nxt_scan = SCAN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_ff <= SCAN_IDLE;
      n_ff <= DIV_MIN;
      switch_divisor_ff <= DIV_MIN;
      divisor_valid_ff <= 1'b0;
    end else begin
      scan_ff <= nxt_scan;
      n_ff <= nxt_n;
      switch_divisor_ff <= nxt_divisor;
      divisor_valid_ff <= nxt_div_valid;
    end
  end

endmodule : vout_limit_freq_config_regs

/* File: logic/pmbus_cfg_pkg.sv */
// Shared constants, types and the linear-11 decoder for the output-limit
// and switching configuration bank.
// Assumes a 200 MHz core clock and a command decoder that hands over whole words.
package pmbus_cfg_pkg;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
  localparam logic [7:0] CMD_CEILING = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_SLEW_RATE = 8'h27;
  localparam logic [7:0] CMD_DUTY_CAP = 8'h32;
  localparam logic [7:0] CMD_SWITCH_FREQ = 8'h33;
  localparam logic [7:0] CMD_EFF_MODE = 8'h34;

  // ----------------------------------------------------------------------
  // Reset values and ranges
  // ----------------------------------------------------------------------
  localparam logic [15:0] SLEW_RESET = 16'hBA00;
  localparam logic [15:0] DUTY_CAP_RESET = 16'hEAD0;
  localparam logic [15:0] SLEW_FASTEST = 16'h7BFF;
  localparam logic [15:0] VOUT_MIN_CODE = 16'h0334;
  localparam logic [15:0] OUTPUT_VOLTAGE_CEILING_CODE = 16'hB000;
  localparam int VOUT_EXP_SHIFT = 13;
  localparam logic [16:0] CEIL_SCALE = 17'h12666;
  localparam logic [16:0] MARGIN_HIGH_SCALE = 17'h10CCD;
  localparam logic [16:0] MARGIN_LOW_SCALE = 17'h0F333;
  localparam int SCALE_SHIFT = 16;
  localparam int DUTY_FRAC_BITS = 3;
  localparam logic [9:0] DUTY_CAP_MAX = 10'h2D0;
  localparam int FREQ_MIN_KHZ = 200;
  localparam int FREQ_MAX_KHZ = 1000;
  localparam int FSW_BASE_KHZ = 30000;
  localparam logic [7:0] DIV_MIN = 8'h1E;
  localparam logic [7:0] DIV_MAX = 8'h96;
  localparam int EFF_DEM_BIT = 0;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_IN_PS = 1000000000;
  localparam int CLK_PER_MS = MS_IN_PS / CLK_PERIOD_PS;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {MARGIN_OFF, MARGIN_HIGH, MARGIN_LOW} margin_sel_t;
  typedef enum logic {SCAN_IDLE, SCAN_RUN} scan_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] data;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] vset;
    logic [15:0] freq;
    logic diode_emulation;
  } strap_t;

  // ----------------------------------------------------------------------
  // Linear-11 word to integer, scaled by 2**shift
  // ----------------------------------------------------------------------
  function automatic logic signed [31:0] linear11_value(input logic [15:0] word,
                                                       input int shift);
    int e;
    logic signed [31:0] y;
    e = int'($signed(word[15:11])) + shift;
    y = {{21{word[10]}}, word[10:0]};
    if (e > 20) begin
      e = 20;
    end
    if (e < -31) begin
      e = -31;
    end
    if (e >= 0) begin
      linear11_value = y <<< e;
    end else begin
      linear11_value = y >>> (-e);
    end
  endfunction : linear11_value

endpackage : pmbus_cfg_pkg

/* File: logic/target_ramp.sv */
// Output target ramp: walks the voltage target one LSB at a time at a rate
// given in LSB per millisecond, or jumps at once when told to or when the rate reaches one LSB per clock.
// Assumes goal and rate come from logic on the same clock.
module target_ramp (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Ramp control
  input wire logic [15:0] goal,
  input wire logic [31:0] rate_per_ms,
  input wire logic instant,
  // Ramp state
  output logic [15:0] target_ff,
  output logic settled_ff
);
  import pmbus_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // Step accumulator
  // ----------------------------------------------------------------------
  logic [31:0] acc_ff;
  logic [31:0] nxt_acc;
  logic [15:0] nxt_target;
  logic nxt_settled;
  logic [31:0] acc_sum;

  // One LSB step each time the accumulator passes a millisecond of cycles
  always_comb begin
    acc_sum = acc_ff + rate_per_ms;
    nxt_acc = acc_ff;
    nxt_target = target_ff;
    if (instant || rate_per_ms >= 32'(CLK_PER_MS)) begin
      nxt_target = goal;
      nxt_acc = '0;
    end else if (target_ff == goal) begin
      nxt_acc = '0;
    end else if (acc_sum >= 32'(CLK_PER_MS)) begin
      nxt_acc = acc_sum - 32'(CLK_PER_MS);
      if (goal > target_ff) begin
        nxt_target = target_ff + 16'h0001;
      end else begin
        nxt_target = target_ff - 16'h0001;
      end
    end else begin
      nxt_acc = acc_sum;
    end
    nxt_settled = (nxt_target == goal);
  end

  // Ramp registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= '0;
      target_ff <= '0;
      settled_ff <= 1'b1;
    end else begin
      acc_ff <= nxt_acc;
      target_ff <= nxt_target;
      settled_ff <= nxt_settled;
    end
  end

endmodule : target_ramp

/* File: test/vout_limit_freq_config_regs_sva.sv */
// Port-level property checker for the configuration bank.
// Assumes it is bound to the bank and sees its ports only.
module vout_limit_freq_config_regs_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command access
  input wire pmbus_cfg_pkg::reg_req_t req,
  input wire logic [15:0] rd_data_ff,
  input wire logic rd_valid_ff,
  input wire logic wr_reject_ff,
  // Context
  input wire pmbus_cfg_pkg::margin_sel_t margin_sel,
  input wire logic power_transition,
  // Derived controls
  input wire logic defaults_loaded_ff,
  input wire logic vout_settled_ff,
  input wire logic [9:0] duty_cap_ff,
  input wire logic [7:0] switch_divisor_ff,
  input wire logic divisor_valid_ff,
  input wire logic diode_emulation_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmbus_cfg_pkg::*;
  // ----------------------------------------------------------------------
  // Properties, all on the core clock
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Answer timing and data hold
  chk_read_answer: assert property (req.rd |=> rd_valid_ff)
    else $error("read not answered one cycle later");
  chk_read_hold: assert property (!rd_valid_ff |-> $stable(rd_data_ff))
    else $error("read data moved without a read");
  chk_reject_cause: assert property (wr_reject_ff |-> $past(req.wr && defaults_loaded_ff))
    else $error("reject pulse without a taken write");
  chk_ceiling_range: assert property (req.wr && defaults_loaded_ff && req.code == CMD_CEILING
    && (req.data < VOUT_MIN_CODE || req.data > OUTPUT_VOLTAGE_CEILING_CODE) |=> wr_reject_ff)
    else $error("out of range ceiling not refused");
  chk_duty_bound: assert property (duty_cap_ff <= DUTY_CAP_MAX)
    else $error("duty cap above ninety percent");
  chk_divisor_span: assert property (divisor_valid_ff |-> switch_divisor_ff inside
    {[DIV_MIN:DIV_MAX]})
    else $error("divisor outside its span");
  chk_mode_copy: assert property (req.wr && defaults_loaded_ff && req.code == CMD_EFF_MODE
    |=> ##1 diode_emulation_ff == $past(req.data[0], 2))
    else $error("diode emulation not copied from bit 0");
  // Quiet goal during a power transition must be reached without slew
  chk_jump_target: assert property ((power_transition && defaults_loaded_ff && !req.wr
    && $stable(margin_sel))[*5] |-> vout_settled_ff)
    else $error("target not at goal during power transition");
endmodule : vout_limit_freq_config_regs_sva

bind vout_limit_freq_config_regs vout_limit_freq_config_regs_sva i_sva (.clk, .rst_n, .req,
  .rd_data_ff, .rd_valid_ff, .wr_reject_ff, .margin_sel, .power_transition,
  .defaults_loaded_ff, .vout_settled_ff, .duty_cap_ff, .switch_divisor_ff,
  .divisor_valid_ff, .diode_emulation_ff);

/* File: test/pmbus_host_model.sv */
// Management host model issuing whole-word accesses to the bank.
// Assumes the bank answers a read or refuses a write one clock later.
module pmbus_host_model (
  // Clock
  input wire logic clk,
  // Bank access
  output pmbus_cfg_pkg::reg_req_t req,
  input wire logic rd_valid_ff,
  input wire logic [15:0] rd_data_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmbus_cfg_pkg::*;
  // Idle bus
  initial req = '{wr: 1'b0, rd: 1'b0, code: 8'h00, data: 16'h0000};
  // Voltage set by command word, duty cap used only as a limit
  // Frequency written only with the output held in transition
  task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic [15:0] word);
    @(negedge clk);
    req <= '{wr: wr, rd: !wr, code: code, data: data};
    @(negedge clk);
    // Released bus shows inverted values so stale data cannot match
    req <= '{wr: 1'b0, rd: 1'b0, code: ~code, data: ~data};
    word = (rd_valid_ff === 1'b1) ? rd_data_ff : 16'hXXXX;
  endtask : access
endmodule : pmbus_host_model

/* File: test/vout_limit_freq_config_regs_test.sv */
// Self-checking bench for the configuration bank.
// Assumes the host model drives requests and straps stay fixed.
module vout_limit_freq_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pmbus_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t req;
  logic [15:0] rd_data_ff, vout_target_ff, rd_word;
  logic rd_valid_ff, wr_reject_ff, defaults_loaded_ff, vout_settled_ff;
  logic divisor_valid_ff, diode_emulation_ff;
  logic [9:0] duty_cap_ff;
  logic [7:0] switch_divisor_ff;
  strap_t strap_pin = '{vset: 16'h2000, freq: 16'h01F4, diode_emulation: 1'b1};
  margin_sel_t margin_sel = MARGIN_OFF;
  logic power_transition = 1'b1;
  int err_total = 0;
  int checks_done = 0;
  // 200 MHz core clock
  always #2.5 clk = ~clk;
  vout_limit_freq_config_regs i_dut (.clk(clk), .rst_n(rst_n), .req(req),
    .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .wr_reject_ff(wr_reject_ff),
    .strap_pin(strap_pin), .margin_sel(margin_sel), .power_transition(power_transition),
    .defaults_loaded_ff(defaults_loaded_ff), .vout_target_ff(vout_target_ff),
    .vout_settled_ff(vout_settled_ff), .duty_cap_ff(duty_cap_ff),
    .switch_divisor_ff(switch_divisor_ff), .divisor_valid_ff(divisor_valid_ff),
    .diode_emulation_ff(diode_emulation_ff));
  pmbus_host_model i_host (.clk(clk), .req(req), .rd_valid_ff(rd_valid_ff),
    .rd_data_ff(rd_data_ff));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : compare
  task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic rej);
    i_host.access(1'b1, code, data, rd_word);
    compare($sformatf("reject %h", code), {15'h0000, rej}, {15'h0000, wr_reject_ff});
  endtask : wr
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    i_host.access(1'b0, code, 16'h0000, rd_word);
    compare($sformatf("reg %h", code), exp, rd_word);
  endtask : rd
  // Bounded wait on loaded (0), settled (1) or divisor valid (2)
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    repeat (2) @(negedge clk);
    while (n < 300 && (sel == 0 ? defaults_loaded_ff : sel == 1 ? vout_settled_ff
           : divisor_valid_ff) !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    if (n == 300) begin
      err_total++;
      $display("[FAIL] wait %0d expected done seen timeout", sel);
      print_verdict();
    end
  endtask : wait_for
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_defaults();
    rd(CMD_CEILING, 16'h24CC);
    rd(CMD_MARGIN_HIGH, 16'h2199);
    rd(CMD_MARGIN_LOW, 16'h1E66);
    rd(CMD_SLEW_RATE, 16'hBA00);
    rd(CMD_DUTY_CAP, 16'hEAD0);
    compare("duty", 16'h02D0, {6'h00, duty_cap_ff});
    rd(CMD_SWITCH_FREQ, 16'h01F4);
    rd(CMD_EFF_MODE, 16'h0001);
    compare("diode", 16'h0001, {15'h0000, diode_emulation_ff});
    rd(8'h99, 16'h0000);
    wait_for(2);
    compare("divisor", 16'h003C, {8'h00, switch_divisor_ff});
  endtask : t_defaults
  task automatic t_ceiling();
    logic [15:0] bad [3] = '{16'h0333, 16'hB001, 16'hFFFF};
    foreach (bad[i]) begin
      wr(CMD_CEILING, bad[i], 1'b1);
    end
    rd(CMD_CEILING, 16'h24CC);
    wr(CMD_VOUT_COMMAND, 16'h24CD, 1'b1);
    rd(CMD_VOUT_COMMAND, 16'h2000);
    wr(CMD_CEILING, 16'h1800, 1'b0);
    wait_for(1);
    compare("target", 16'h1800, vout_target_ff);
    wr(CMD_CEILING, 16'h0334, 1'b0);
    wait_for(1);
    compare("target", 16'h0334, vout_target_ff);
    wr(CMD_CEILING, 16'hB000, 1'b0);
    wait_for(1);
    compare("target", 16'h2000, vout_target_ff);
    wr(CMD_CEILING, 16'h24CC, 1'b0);
  endtask : t_ceiling
  task automatic t_margin();
    wr(CMD_MARGIN_HIGH, 16'h24CD, 1'b1);
    wr(CMD_MARGIN_LOW, 16'h0333, 1'b1);
    wr(CMD_MARGIN_LOW, 16'h1E00, 1'b0);
    margin_sel = MARGIN_HIGH;
    wait_for(1);
    compare("target", 16'h2199, vout_target_ff);
    margin_sel = MARGIN_LOW;
    wait_for(1);
    compare("target", 16'h1E00, vout_target_ff);
    power_transition = 1'b0;
    margin_sel = MARGIN_OFF;
    repeat (30) @(negedge clk);
    compare("slew step", 16'h1E01, vout_target_ff);
    wr(CMD_SLEW_RATE, SLEW_FASTEST, 1'b0);
    wait_for(1);
    compare("target", 16'h2000, vout_target_ff);
    power_transition = 1'b1;
  endtask : t_margin
  task automatic t_freq_mode();
    wr(CMD_SWITCH_FREQ, 16'h03E8, 1'b0);
    wait_for(2);
    compare("divisor", 16'h001E, {8'h00, switch_divisor_ff});
    wr(CMD_SWITCH_FREQ, 16'h00C8, 1'b0);
    wait_for(2);
    compare("divisor", 16'h0096, {8'h00, switch_divisor_ff});
    wr(CMD_SWITCH_FREQ, 16'h00C7, 1'b1);
    wr(CMD_SWITCH_FREQ, 16'h03E9, 1'b1);
    rd(CMD_SWITCH_FREQ, 16'h00C8);
    wr(CMD_DUTY_CAP, 16'hE968, 1'b0);
    // Cap output is one flop behind the stored word
    @(negedge clk);
    compare("duty", 16'h0168, {6'h00, duty_cap_ff});
    wr(CMD_DUTY_CAP, 16'hEAD1, 1'b1);
    rd(CMD_DUTY_CAP, 16'hE968);
    wr(CMD_EFF_MODE, 16'hFFFF, 1'b0);
    rd(CMD_EFF_MODE, 16'h0001);
    wr(CMD_EFF_MODE, 16'h0000, 1'b0);
    // Mode output is one flop behind the stored byte
    @(negedge clk);
    compare("diode", 16'h0000, {15'h0000, diode_emulation_ff});
  endtask : t_freq_mode
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    wait_for(0);
    t_defaults();
    t_ceiling();
    t_margin();
    t_freq_mode();
    print_verdict();
  end
endmodule : vout_limit_freq_config_regs_test
